/* include/cot_pkg.sv */
// Constants and types for the converter offset trim register bank
package cot_pkg;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 8;
  localparam int TRIM_W   = 12;
  localparam int REG_W    = 16;
  localparam int N_TRIM   = 3;
  // Trim register slots
  localparam int SLOT_C1B = 0;
  localparam int SLOT_C2A = 1;
  localparam int SLOT_C2B = 2;
  // Byte addresses; each trim takes a low byte and the next high byte
  localparam logic [ADDR_W-1:0] ADDR_C1B_LO = 12'h090;
  localparam logic [ADDR_W-1:0] ADDR_C2A_LO = 12'h092;
  localparam logic [ADDR_W-1:0] ADDR_C2B_LO = 12'h094;
  localparam logic [ADDR_W-1:0] ADDR_FILT0  = 12'h097;
  localparam logic [N_TRIM-1:0][ADDR_W-1:0] TRIM_BASE = {ADDR_C2B_LO, ADDR_C2A_LO, ADDR_C1B_LO};
  localparam logic [ADDR_W-1:0] ADDR_HI_STEP = 12'h001;
  // Field layout and reset values
  localparam int TRIM_MSB   = 11;
  localparam int LO_MSB     = 7;
  localparam int HI_LSB     = 8;
  localparam int KEEP_DC_BIT = 0;
  localparam logic [3:0]        TRIM_RSV_RST = 4'h0;
  localparam logic [DATA_W-1:0] FILT0_RST    = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE      = 8'h00;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cot_bus_req_t;

  // Calibration engine status seen by the bank
  typedef struct packed {
    logic fg_busy;
    logic background_cal_enable;
    logic background_offset_cal_enable;
    logic offset_cal_enable;
    logic foreground_cal_done;
    logic cal_halted_flag;
  } cot_cal_status_t;

  // Factory trim values, one per slot
  typedef logic [N_TRIM-1:0][TRIM_W-1:0] cot_trim_bank_t;
endpackage : cot_pkg

/* verilog/cot_regs.sv */
// Offset trim register bank with filter control and correction outputs
`timescale 1ns/1ns
module cot_regs (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire cot_pkg::cot_bus_req_t       bus_req,
  output logic [cot_pkg::DATA_W-1:0]       rd_data,
  input  wire cot_pkg::cot_trim_bank_t     factory_trim,
  input  wire cot_pkg::cot_cal_status_t    cal_status,
  input  wire logic                        conv1_on_second,
  input  wire logic                        conv2_on_second,
  output logic [cot_pkg::TRIM_W-1:0]       conv1_corr,
  output logic                             conv1_corr_valid,
  output logic [cot_pkg::TRIM_W-1:0]       conv2_corr,
  output logic                             keep_dc_content,
  output logic                             trim_write_ok,
  output logic                             trim_read_ok
);
  import cot_pkg::*;

  logic [N_TRIM-1:0][REG_W-1:0] trim_reg;
  logic [N_TRIM-1:0][REG_W-1:0] trim_next;
  logic                         filt_reg;
  logic                         filt_next;
  logic [DATA_W-1:0]            rd_data_reg;
  logic [DATA_W-1:0]            rd_data_next;
  logic [TRIM_W-1:0]            c1_corr_reg;
  logic [TRIM_W-1:0]            c1_corr_next;
  logic                         c1_valid_reg;
  logic                         c1_valid_next;
  logic [TRIM_W-1:0]            c2_corr_reg;
  logic [TRIM_W-1:0]            c2_corr_next;
  logic                         wr_ok_reg;
  logic                         wr_ok_next;
  logic                         rd_ok_reg;
  logic                         rd_ok_next;

  // One trim register per slot, low and high byte decoded separately
  genvar gi;
  generate
    for (gi = 0; gi < N_TRIM; gi++) begin : g_trim
      always_comb begin
        trim_next[gi] = trim_reg[gi];
        if (rst) begin
          trim_next[gi] = {TRIM_RSV_RST, factory_trim[gi]};
        end else if (bus_req.wr && bus_req.addr == TRIM_BASE[gi]) begin
          trim_next[gi][LO_MSB:0] = bus_req.wdata;
        end else if (bus_req.wr && bus_req.addr == TRIM_BASE[gi] + ADDR_HI_STEP) begin
          trim_next[gi][REG_W-1:HI_LSB] = bus_req.wdata;
        end
      end

      always_ff @(posedge sys_clk) begin
        trim_reg[gi] <= trim_next[gi];
      end
    end
  endgenerate

  // Offset filter control, only bit 0 is stored
  always_comb begin
    filt_next = filt_reg;
    if (rst) begin
      filt_next = FILT0_RST[KEEP_DC_BIT];
    end else if (bus_req.wr && bus_req.addr == ADDR_FILT0) begin
      filt_next = bus_req.wdata[KEEP_DC_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    filt_reg <= filt_next;
  end

  // Read decode; data stands only in the cycle after the strobe
  always_comb begin
    rd_data_next = RD_IDLE;
    if (!rst && bus_req.rd) begin
      for (int i = 0; i < N_TRIM; i++) begin
        if (bus_req.addr == TRIM_BASE[i]) begin
          rd_data_next = trim_reg[i][LO_MSB:0];
        end
        if (bus_req.addr == TRIM_BASE[i] + ADDR_HI_STEP) begin
          rd_data_next = trim_reg[i][REG_W-1:HI_LSB];
        end
      end
      if (bus_req.addr == ADDR_FILT0) begin
        rd_data_next = FILT0_RST;  // Reserved bits read zero
        rd_data_next[KEEP_DC_BIT] = filt_reg;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data_reg <= rd_data_next;
  end

  // Correction selection by the input each converter samples
  always_comb begin
    c1_corr_next  = {TRIM_W{1'b0}};
    c1_valid_next = 1'b0;
    c2_corr_next  = {TRIM_W{1'b0}};
    if (!rst) begin
      c1_valid_next = conv1_on_second;
      if (conv1_on_second) begin
        c1_corr_next = trim_reg[SLOT_C1B][TRIM_MSB:0];
      end
      c2_corr_next = conv2_on_second ? trim_reg[SLOT_C2B][TRIM_MSB:0]
                                     : trim_reg[SLOT_C2A][TRIM_MSB:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    c1_corr_reg  <= c1_corr_next;
    c1_valid_reg <= c1_valid_next;
    c2_corr_reg  <= c2_corr_next;
  end

  // Access windows the host is expected to honour
  always_comb begin
    wr_ok_next = 1'b0;
    rd_ok_next = 1'b0;
    if (!rst) begin
      wr_ok_next = !cal_status.fg_busy
                   && !(cal_status.background_cal_enable
                        && cal_status.background_offset_cal_enable);
      if (cal_status.offset_cal_enable && !cal_status.background_offset_cal_enable) begin
        rd_ok_next = cal_status.foreground_cal_done;
      end else if (cal_status.background_cal_enable
                   && cal_status.background_offset_cal_enable) begin
        rd_ok_next = cal_status.cal_halted_flag;
      end else begin
        rd_ok_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    wr_ok_reg <= wr_ok_next;
    rd_ok_reg <= rd_ok_next;
  end

  // Output drive
  assign rd_data          = rd_data_reg;
  assign conv1_corr       = c1_corr_reg;
  assign conv1_corr_valid = c1_valid_reg;
  assign conv2_corr       = c2_corr_reg;
  assign keep_dc_content  = filt_reg;
  assign trim_write_ok    = wr_ok_reg;
  assign trim_read_ok     = rd_ok_reg;

  // Checks on the bank's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_conv1_corr_apply: assert property (
    conv1_on_second |=> conv1_corr_valid
      && conv1_corr == $past(trim_reg[SLOT_C1B][TRIM_MSB:0]))
    else $error("conv1 correction not taken from its trim");

  a_conv2_input_sel: assert property (
    1'b1 |=> conv2_corr == ($past(conv2_on_second)
      ? $past(trim_reg[SLOT_C2B][TRIM_MSB:0])
      : $past(trim_reg[SLOT_C2A][TRIM_MSB:0])))
    else $error("conv2 correction from wrong input trim");

  a_corr_no_rsv: assert property (
    (bus_req.wr && bus_req.addr == TRIM_BASE[SLOT_C2A] + ADDR_HI_STEP
      && !conv2_on_second) ##1 !conv2_on_second
      |=> conv2_corr[TRIM_MSB:HI_LSB] == $past(bus_req.wdata[TRIM_MSB-HI_LSB:0], 2)
          && conv2_corr[LO_MSB:0] == $past(trim_reg[SLOT_C2A][LO_MSB:0]))
    else $error("conv2 correction not unsigned trim field");

  a_trim_factory: assert property (
    $fell(rst) |-> trim_reg[SLOT_C1B] == {TRIM_RSV_RST, $past(factory_trim[SLOT_C1B])}
      && trim_reg[SLOT_C2B] == {TRIM_RSV_RST, $past(factory_trim[SLOT_C2B])})
    else $error("trim not loaded with factory value");

  a_trim_write_rd: assert property (
    (bus_req.wr && bus_req.addr == ADDR_C2B_LO)
      ##1 (bus_req.rd && bus_req.addr == ADDR_C2B_LO && !bus_req.wr)
      |=> rd_data == $past(bus_req.wdata, 2))
    else $error("trim low byte write not read back");

  a_filt_reset: assert property (
    $fell(rst) |-> !filt_reg ##0 rd_data == RD_IDLE)
    else $error("filter control not reset to zero");

  a_filt_read: assert property (
    (bus_req.rd && bus_req.addr == ADDR_FILT0)
      |=> rd_data[DATA_W-1:1] == 7'h00 && rd_data[KEEP_DC_BIT] == $past(filt_reg))
    else $error("filter control read wrong");

  a_keep_dc_follow: assert property (
    (bus_req.wr && bus_req.addr == ADDR_FILT0)
      |=> keep_dc_content == $past(bus_req.wdata[KEEP_DC_BIT]))
    else $error("keep dc output not following write");

  a_write_window: assert property (
    (cal_status.background_cal_enable && cal_status.background_offset_cal_enable)
      |=> !trim_write_ok)
    else $error("write window open under background offset cal");

  // Correction path checks
  a_c1_idle_zero: assert property (
    !conv1_on_second
      |=> !conv1_corr_valid && conv1_corr == {TRIM_W{1'b0}})
    else $error("conv1 correction not cleared when idle");

  a_c1_valid_follow: assert property (
    1'b1
      |=> conv1_corr_valid == $past(conv1_on_second))
    else $error("conv1 valid not one cycle behind select");

  a_c2a_select: assert property (
    !conv2_on_second
      |=> conv2_corr == $past(trim_reg[SLOT_C2A][TRIM_MSB:0]))
    else $error("conv2 first input trim not applied");

  a_c2b_select: assert property (
    conv2_on_second
      |=> conv2_corr == $past(trim_reg[SLOT_C2B][TRIM_MSB:0]))
    else $error("conv2 second input trim not applied");

  a_c2_unsigned_top: assert property (
    conv2_on_second
      |=> conv2_corr[TRIM_MSB:HI_LSB] == $past(trim_reg[SLOT_C2B][TRIM_MSB:HI_LSB]))
    else $error("conv2 correction upper bits altered");

  // Trim storage checks
  a_c2a_factory: assert property (
    $fell(rst)
      |-> trim_reg[SLOT_C2A] == {TRIM_RSV_RST, $past(factory_trim[SLOT_C2A])})
    else $error("conv2 first input trim not factory loaded");

  a_c1b_lo_write: assert property (
    bus_req.wr && bus_req.addr == ADDR_C1B_LO
      |=> trim_reg[SLOT_C1B][LO_MSB:0] == $past(bus_req.wdata))
    else $error("conv1 trim low byte write lost");

  a_c1b_hi_write: assert property (
    bus_req.wr && bus_req.addr == ADDR_C1B_LO + ADDR_HI_STEP
      |=> trim_reg[SLOT_C1B][REG_W-1:HI_LSB] == $past(bus_req.wdata))
    else $error("conv1 trim high byte write lost");

  a_c2a_lo_write: assert property (
    bus_req.wr && bus_req.addr == ADDR_C2A_LO
      |=> trim_reg[SLOT_C2A][LO_MSB:0] == $past(bus_req.wdata))
    else $error("conv2 first trim low byte write lost");

  a_c2b_hi_write: assert property (
    bus_req.wr && bus_req.addr == ADDR_C2B_LO + ADDR_HI_STEP
      |=> trim_reg[SLOT_C2B][REG_W-1:HI_LSB] == $past(bus_req.wdata))
    else $error("conv2 second trim high byte write lost");

  a_trim_hold: assert property (
    !bus_req.wr
      |=> $stable(trim_reg))
    else $error("trim changed without a write");

  // Read port and filter output checks
  a_rd_idle: assert property (
    !bus_req.rd
      |=> rd_data == RD_IDLE)
    else $error("read data not idle without a read");

  a_rd_c1b_lo: assert property (
    bus_req.rd && bus_req.addr == ADDR_C1B_LO
      |=> rd_data == $past(trim_reg[SLOT_C1B][LO_MSB:0]))
    else $error("conv1 trim low byte read wrong");

  a_rd_c2a_hi: assert property (
    bus_req.rd && bus_req.addr == ADDR_C2A_LO + ADDR_HI_STEP
      |=> rd_data == $past(trim_reg[SLOT_C2A][REG_W-1:HI_LSB]))
    else $error("conv2 first trim high byte read wrong");

  a_filt_hold: assert property (
    !(bus_req.wr && bus_req.addr == ADDR_FILT0)
      |=> $stable(keep_dc_content))
    else $error("keep dc output changed without a write");

  // Access window checks
  a_wr_ok_fg: assert property (
    cal_status.fg_busy
      |=> !trim_write_ok)
    else $error("write window open during foreground cal");

  a_wr_ok_open: assert property (
    !cal_status.fg_busy && !cal_status.background_offset_cal_enable
      |=> trim_write_ok)
    else $error("write window shut with calibration idle");

  a_rd_ok_fg: assert property (
    cal_status.offset_cal_enable && !cal_status.background_offset_cal_enable
      |=> trim_read_ok == $past(cal_status.foreground_cal_done))
    else $error("read window not tied to foreground done");

  a_rd_ok_bg: assert property (
    cal_status.background_cal_enable && cal_status.background_offset_cal_enable
      |=> trim_read_ok == $past(cal_status.cal_halted_flag))
    else $error("read window not tied to cal halted");

  a_rd_ok_free: assert property (
    !cal_status.offset_cal_enable && !cal_status.background_cal_enable
      |=> trim_read_ok)
    else $error("read window shut with calibration off");

endmodule : cot_regs

/* verif/tb_cot_regs.sv */
// Self-checking testbench for the converter offset trim register bank
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("ERROR at %0t: got 0x%0h, expected 0x%0h", $time, (got), (exp)); \
    end \
  end
module tb_cot_regs;
  import cot_pkg::*;
  // Factory trims, arbitrary test values
  localparam cot_trim_bank_t FAC = {12'hC3A, 12'h5B7, 12'hF0E};
  logic                   sys_clk;
  logic                   rst;
  cot_bus_req_t           bus_req;
  logic [DATA_W-1:0]      rd_data;
  cot_trim_bank_t         factory_trim;
  cot_cal_status_t        cal_status;
  logic                   conv1_on_second;
  logic                   conv2_on_second;
  logic [TRIM_W-1:0]      conv1_corr;
  logic                   conv1_corr_valid;
  logic [TRIM_W-1:0]      conv2_corr;
  logic                   keep_dc_content;
  logic                   trim_write_ok;
  logic                   trim_read_ok;
  logic [REG_W-1:0]       shadow [N_TRIM];
  int                     n_mismatch;
  int                     n_tests;

  cot_regs cot_regs_inst (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .factory_trim(factory_trim), .cal_status(cal_status), .conv1_on_second(conv1_on_second),
    .conv2_on_second(conv2_on_second), .conv1_corr(conv1_corr),
    .conv1_corr_valid(conv1_corr_valid), .conv2_corr(conv2_corr),
    .keep_dc_content(keep_dc_content), .trim_write_ok(trim_write_ok),
    .trim_read_ok(trim_read_ok));

  // Free-running 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // One-cycle write strobe
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    bus_req <= {a, d, 2'b10};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : bus_wr

  // One-cycle read strobe, data judged in the following cycle
  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge sys_clk);
    bus_req <= {a, 8'h00, 2'b01};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 `CHK(rd_data, e)
  endtask : chk_rd

  // Trim register access as low byte then high byte
  task automatic wr_trim(input int s, input logic [REG_W-1:0] v);
    bus_wr(TRIM_BASE[s], v[7:0]);
    bus_wr(TRIM_BASE[s] + ADDR_HI_STEP, v[15:8]);
    shadow[s] = v;
  endtask : wr_trim

  task automatic chk_trim(input int s);
    chk_rd(TRIM_BASE[s], shadow[s][7:0]);
    chk_rd(TRIM_BASE[s] + ADDR_HI_STEP, shadow[s][15:8]);
  endtask : chk_trim

  // Factory trims and filter control after reset
  task automatic t_reset();
    for (int s = 0; s < N_TRIM; s++) begin
      shadow[s] = {TRIM_RSV_RST, FAC[s]};
      chk_trim(s);
    end
    chk_rd(ADDR_FILT0, FILT0_RST);
    @(posedge sys_clk);
    #1 `CHK(rd_data, RD_IDLE)
  endtask : t_reset

  // Writes replace trims, reserved nibble included; hole at 0x096 ignored
  task automatic t_write();
    wr_trim(SLOT_C1B, 16'hA123);
    wr_trim(SLOT_C2A, 16'h0FFF);
    wr_trim(SLOT_C2B, 16'h5000);
    // Write then read with no gap
    @(posedge sys_clk);
    bus_req <= {ADDR_C2B_LO, 8'h5A, 2'b10};
    @(posedge sys_clk);
    bus_req <= {ADDR_C2B_LO, 8'h00, 2'b01};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 `CHK(rd_data, 8'h5A)
    shadow[SLOT_C2B][7:0] = 8'h5A;
    bus_wr(12'h096, 8'hFF);
    chk_rd(12'h096, 8'h00);
    for (int s = 0; s < N_TRIM; s++) chk_trim(s);
  endtask : t_write

  // Corrections follow the input selection one cycle later
  task automatic t_corr();
    @(posedge sys_clk);
    conv1_on_second <= 1'b1;
    conv2_on_second <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK(conv1_corr, shadow[SLOT_C1B][TRIM_MSB:0])
    `CHK(conv1_corr_valid, 1'b1)
    `CHK(conv2_corr, shadow[SLOT_C2A][TRIM_MSB:0])
    @(posedge sys_clk);
    conv1_on_second <= 1'b0;
    conv2_on_second <= 1'b1;
    @(posedge sys_clk);
    #1 `CHK(conv1_corr_valid, 1'b0)
    `CHK(conv2_corr, shadow[SLOT_C2B][TRIM_MSB:0])
  endtask : t_corr

  // Filter control bit 0 only; reserved bits read zero
  task automatic t_filter();
    bus_wr(ADDR_FILT0, 8'hFF);
    #1 `CHK(keep_dc_content, 1'b1)
    chk_rd(ADDR_FILT0, 8'h01);
    bus_wr(ADDR_FILT0, 8'h00);
    #1 `CHK(keep_dc_content, 1'b0)
    chk_rd(ADDR_FILT0, 8'h00);
  endtask : t_filter

  // Advisory access flags over every calibration status combination
  task automatic t_cal();
    logic [5:0] c;
    for (int i = 0; i < 64; i++) begin
      c = i[5:0];
      @(posedge sys_clk);
      cal_status <= cot_cal_status_t'(c);
      @(posedge sys_clk);
      #1 `CHK(trim_write_ok, !c[5] && !(c[4] && c[3]))
      `CHK(trim_read_ok, (c[2] && !c[3]) ? c[1] : ((c[4] && c[3]) ? c[0] : 1'b1))
    end
  endtask : t_cal

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    factory_trim = FAC;
    cal_status = '0;
    conv1_on_second = 1'b0;
    conv2_on_second = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_write();
    t_corr();
    t_filter();
    t_cal();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule : tb_cot_regs
